// File: logic/supervisor_pkg.sv
// constants and types for the system supervisor
//Contract
//RULE_01: hold power-on reset 10 to 80 us
//RULE_02: expect both supplies within check window
//RULE_03: timer expiry gives ~8 us processor reset
//RULE_04: system reset lasts 0.4 to 1.5 ms
//RULE_05: supervision timer runs on slow oscillator
//RULE_06: timer counts selected timeout, then resets processor
//RULE_07: firmware restarts timer before timeout
//RULE_08: tally supervision resets, limit 4 or 8
//RULE_09: tally at limit gives global reset
//RULE_10: fast oscillator divided by 5 for logic
//RULE_11: sleep moves logic to slow oscillator
//RULE_12: wake detection on slow oscillator in sleep
//RULE_13: sleep switches off three processor supplies
//RULE_14: sleep keeps primary analog, logic supply
//RULE_15: charge pump ready within 2 ms
//RULE_16: power-up timer before processor supplies enable; code enables secondary analog at the start of power-up
//RULE_17: supplies valid: clock on, reset released
//RULE_18: window missed: clock stopped, reset held
package supervisor_pkg;
  localparam int CLK_MHZ = 100;
  localparam int FAST_MHZ = 20;
  localparam int FAST_DIV = CLK_MHZ / FAST_MHZ;
  localparam int LOGIC_DIV = 5;
  localparam int SLOW_KHZ = 125;
  localparam int SLOW_DIV = CLK_MHZ * 1000 / SLOW_KHZ;
  localparam int TW = 18;
  localparam int POR_HOLD_US = 10;
  localparam int PWRUP_US = 780;
  localparam int CHECK_US = 1660;
  localparam int SYSRST_US = 950;
  localparam int CP_SETTLE_US = 2000;
  localparam int MCU_RST_US = 8;
  localparam logic [TW-1:0] POR_HOLD_CYC = TW'(POR_HOLD_US * CLK_MHZ);
  localparam logic [TW-1:0] PWRUP_CYC = TW'(PWRUP_US * CLK_MHZ);
  localparam logic [TW-1:0] CHECK_CYC = TW'(CHECK_US * CLK_MHZ);
  localparam logic [TW-1:0] SYSRST_CYC = TW'(SYSRST_US * CLK_MHZ);
  localparam logic [TW-1:0] CP_CYC = TW'(CP_SETTLE_US * CLK_MHZ);
  localparam logic [TW-1:0] MCU_RST_TICKS = TW'((MCU_RST_US * SLOW_KHZ + 999) / 1000);
  localparam logic [TW-1:0] SUPV_BASE_TICKS = 18'h00100;
  localparam logic [3:0] TALLY_LO = 4'h4;
  localparam logic [3:0] TALLY_HI = 4'h8;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CFG = 4'h1;
  localparam logic [3:0] ADDR_STATE = 4'h2;
  localparam logic [3:0] ADDR_STAT = 4'h3;
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_KICK_BIT = 1;
  localparam int CFG_LIMIT_BIT = 2;
  localparam logic [7:0] CFG_RESET = 8'h00;
  typedef enum logic [6:0] {
    S_POR = 7'h01,
    S_PWRUP = 7'h02,
    S_CHECK = 7'h04,
    S_NORMAL = 7'h08,
    S_SLEEP = 7'h10,
    S_SYSRST = 7'h20,
    S_FAIL = 7'h40
  } seq_state_t;
  typedef struct packed {
    logic vsup_ok;
    logic core_ok;
    logic periph_ok;
    logic cp_ok;
    logic bus_wake;
  } pin_in_t;
  typedef struct packed {
    logic prim_analog;
    logic sec_analog;
    logic periph;
    logic basis_logic;
    logic core_buf;
  } supply_en_t;
endpackage : supervisor_pkg

// File: logic/tick_divider.sv
// enable-pulse divider: one tick every DIV enabled cycles
`timescale 1ns/1ps
module tick_divider #(
  parameter int DIV = 5
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic en,
  output logic tick
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (en) begin
      if (cnt_q == CW'(DIV - 1)) begin
        cnt_d = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
  assign tick = tick_q;
endmodule : tick_divider

// File: logic/pulse_timer.sv
// loadable down counter; expired while it stands at zero
`timescale 1ns/1ps
module pulse_timer #(
  parameter logic [17:0] INIT = 18'h00001
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [17:0] load_val,
  input wire logic step,
  output logic expired
);
  logic [17:0] cnt_q, cnt_d;
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_val;
    end else if (step && cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= INIT;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign expired = (cnt_q == '0);
endmodule : pulse_timer

// File: logic/system_supervisor_watchdog.sv
// power sequencer, supervision timer and sleep control
`timescale 1ns/1ps
module system_supervisor_watchdog #(
  parameter logic [17:0] PWRUP_LEN = supervisor_pkg::PWRUP_CYC,
  parameter logic [17:0] CHECK_LEN = supervisor_pkg::CHECK_CYC,
  parameter logic [17:0] SYSRST_LEN = supervisor_pkg::SYSRST_CYC,
  parameter logic [17:0] CP_LEN = supervisor_pkg::CP_CYC,
  parameter logic [17:0] SUPV_LEN = supervisor_pkg::SUPV_BASE_TICKS
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire supervisor_pkg::pin_in_t pins,
  output supervisor_pkg::supply_en_t supply_en,
  output logic por_active,
  output logic mcu_rst_n,
  output logic mcu_clk_en,
  output logic sys_rst,
  output logic drivers_en,
  output logic logic_tick,
  output logic logic_on_slow,
  output logic cp_ready
);
  import supervisor_pkg::*;

  pin_in_t meta_q, pin_q;
  seq_state_t state_q, state_d;
  logic fast_tick, logic_fast_tick, slow_tick;
  logic phase_load, phase_done;
  logic [17:0] phase_val;
  logic supv_load, supv_done, supv_fire;
  logic [17:0] supv_val;
  logic cp_load, cp_done;
  logic [3:0] tally_q, tally_d;
  logic tally_hit;
  logic mrst_q, mrst_d;
  logic [17:0] mrst_cnt_q, mrst_cnt_d;
  logic wake_q, wake_d;
  logic [7:0] cfg_q, cfg_d, rdata_q, rdata_d;
  logic sleep_req, kick;
  supply_en_t sup_q, sup_d;
  logic por_q, por_d, rstn_q, rstn_d, clken_q, clken_d;
  logic sysrst_q, sysrst_d, drv_q, drv_d, ltick_q, ltick_d;
  logic slow_q, slow_d, cp_q, cp_d;

  // pins leave their own domain here; nothing reads meta_q but pin_q
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      pin_q <= '0;
    end else begin
      meta_q <= pins;
      pin_q <= meta_q;
    end
  end

  // RULE_10 fast oscillator, divided by 5
  tick_divider #(.DIV(FAST_DIV)) u_fast (
    .sys_clk(sys_clk), .resetn(resetn), .en(1'b1), .tick(fast_tick));
  tick_divider #(.DIV(LOGIC_DIV)) u_logic (
    .sys_clk(sys_clk), .resetn(resetn), .en(fast_tick), .tick(logic_fast_tick));
  // RULE_05 independent slow oscillator
  tick_divider #(.DIV(SLOW_DIV)) u_slow (
    .sys_clk(sys_clk), .resetn(resetn), .en(1'b1), .tick(slow_tick));

  pulse_timer #(.INIT(POR_HOLD_CYC)) u_phase (
    .sys_clk(sys_clk), .resetn(resetn), .load(phase_load),
    .load_val(phase_val), .step(1'b1), .expired(phase_done));
  // RULE_05 supervision count steps only on slow ticks
  pulse_timer #(.INIT(SUPV_LEN)) u_supv (
    .sys_clk(sys_clk), .resetn(resetn), .load(supv_load),
    .load_val(supv_val), .step(slow_tick), .expired(supv_done));
  pulse_timer #(.INIT(CP_CYC)) u_cp (
    .sys_clk(sys_clk), .resetn(resetn), .load(cp_load),
    .load_val(CP_LEN), .step(1'b1), .expired(cp_done));

  // register port: writes act at once, reads answer one cycle later
  always_comb begin
    cfg_d = cfg_q;
    rdata_d = 8'h00;
    sleep_req = wr_en && addr == ADDR_CTRL && wdata[CTRL_SLEEP_BIT];
    // RULE_07 firmware restart arrives here
    kick = wr_en && addr == ADDR_CTRL && wdata[CTRL_KICK_BIT];
    if (wr_en && addr == ADDR_CFG) begin
      cfg_d = {5'h00, wdata[2:0]};
    end
    if (rd_en) begin
      unique case (addr)
        ADDR_CFG: rdata_d = cfg_q;
        ADDR_STATE: rdata_d = {1'b0, state_q};
        ADDR_STAT: rdata_d = {cp_q, mrst_q, wake_q, 1'b0, tally_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= CFG_RESET;
      rdata_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  // RULE_06 selected timeout; restart only counts while running
  assign supv_val = SUPV_LEN << cfg_q[1:0];
  assign supv_fire = state_q == S_NORMAL && supv_done;
  assign supv_load = kick || supv_fire || state_q != S_NORMAL;
  // RULE_08 limit of 4 or 8
  assign tally_hit = tally_q >= (cfg_q[CFG_LIMIT_BIT] ? TALLY_HI : TALLY_LO);
  assign cp_load = state_q != S_CHECK && state_q != S_NORMAL;

  // sequencer
  always_comb begin
    state_d = state_q;
    phase_load = 1'b0;
    phase_val = POR_HOLD_CYC;
    tally_d = tally_q;
    if (!pin_q.vsup_ok) begin
      state_d = S_POR;
      phase_load = 1'b1;
    end else begin
      unique case (state_q)
        // RULE_01 hold reset after supply good
        S_POR: if (phase_done) begin
          state_d = S_PWRUP;
          phase_load = 1'b1;
          phase_val = PWRUP_LEN;
        end
        // RULE_16 oscillators settle before periph and core buffer supplies
        S_PWRUP: if (phase_done) begin
          state_d = S_CHECK;
          phase_load = 1'b1;
          phase_val = CHECK_LEN;
        end
        // RULE_02 both valid inside window
        S_CHECK: if (pin_q.core_ok && pin_q.periph_ok) begin
          state_d = S_NORMAL;
        end else if (phase_done) begin
          // RULE_18 missed window locks out
          state_d = S_FAIL;
        end
        S_NORMAL: begin
          if (supv_fire) begin
            // RULE_08 count supervision resets
            tally_d = tally_q + 1'b1;
          end
          if (tally_hit) begin
            // RULE_09 escalate to global reset
            state_d = S_SYSRST;
            phase_load = 1'b1;
            phase_val = SYSRST_LEN;
          end else if (sleep_req) begin
            state_d = S_SLEEP;
          end
        end
        S_SLEEP: if (wake_q) begin
          state_d = S_CHECK;
          phase_load = 1'b1;
          phase_val = CHECK_LEN;
        end
        // RULE_04 global reset length
        S_SYSRST: begin
          tally_d = 4'h0;
          if (phase_done) begin
            state_d = S_PWRUP;
            phase_load = 1'b1;
            phase_val = PWRUP_LEN;
          end
        end
        S_FAIL: state_d = S_FAIL;
        default: state_d = S_POR;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_POR;
      tally_q <= 4'h0;
    end else begin
      state_q <= state_d;
      tally_q <= tally_d;
    end
  end

  // processor reset pulse and wake sampling, both on slow ticks
  always_comb begin
    mrst_d = mrst_q;
    mrst_cnt_d = mrst_cnt_q;
    wake_d = 1'b0;
    // RULE_03 pulse timed in slow ticks
    if (supv_fire) begin
      mrst_d = 1'b1;
      mrst_cnt_d = MCU_RST_TICKS;
    end else if (mrst_q && slow_tick) begin
      mrst_cnt_d = mrst_cnt_q - 1'b1;
      mrst_d = mrst_cnt_q != 18'h00001;
    end
    // RULE_12 wake seen only at slow ticks
    if (state_q == S_SLEEP) begin
      wake_d = slow_tick ? pin_q.bus_wake : wake_q;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mrst_q <= 1'b0;
      mrst_cnt_q <= '0;
      wake_q <= 1'b0;
    end else begin
      mrst_q <= mrst_d;
      mrst_cnt_q <= mrst_cnt_d;
      wake_q <= wake_d;
    end
  end

  // registered outputs, from the current state plus reset pulse, ticks and pump flag
  always_comb begin
    por_d = state_q == S_POR;
    sup_d.prim_analog = 1'b0;
    sup_d.basis_logic = 1'b0;
    sup_d.sec_analog = 1'b0;
    sup_d.periph = 1'b0;
    sup_d.core_buf = 1'b0;
    if (state_q != S_POR) begin
      // RULE_14 these two stay on in sleep
      sup_d.prim_analog = 1'b1;
      sup_d.basis_logic = 1'b1;
    end
    // RULE_13 sleep drops the processor supplies
    if (state_q inside {S_PWRUP, S_CHECK, S_NORMAL, S_FAIL}) begin
      sup_d.sec_analog = 1'b1;
    end
    // RULE_16 periph and core buffer only from the check on; sec_analog already from power-up
    if (state_q inside {S_CHECK, S_NORMAL, S_FAIL}) begin
      sup_d.periph = 1'b1;
      sup_d.core_buf = 1'b1;
    end
    // RULE_17 clock and reset release in normal
    clken_d = state_q == S_NORMAL;
    rstn_d = state_q == S_NORMAL && !mrst_q;
    sysrst_d = state_q == S_SYSRST;
    drv_d = state_q == S_NORMAL;
    // RULE_11 logic clock source follows sleep
    slow_d = state_q == S_SLEEP;
    ltick_d = slow_d ? slow_tick : logic_fast_tick;
    // RULE_15 ready on pump good or settle limit
    cp_d = !cp_load && (cp_q || pin_q.cp_ok || cp_done);
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sup_q <= '0;
      por_q <= 1'b1;
      clken_q <= 1'b0;
      rstn_q <= 1'b0;
      sysrst_q <= 1'b0;
      drv_q <= 1'b0;
      slow_q <= 1'b0;
      ltick_q <= 1'b0;
      cp_q <= 1'b0;
    end else begin
      sup_q <= sup_d;
      por_q <= por_d;
      clken_q <= clken_d;
      rstn_q <= rstn_d;
      sysrst_q <= sysrst_d;
      drv_q <= drv_d;
      slow_q <= slow_d;
      ltick_q <= ltick_d;
      cp_q <= cp_d;
    end
  end
  assign rdata = rdata_q;
  assign supply_en = sup_q;
  assign por_active = por_q;
  assign mcu_rst_n = rstn_q;
  assign mcu_clk_en = clken_q;
  assign sys_rst = sysrst_q;
  assign drivers_en = drv_q;
  assign logic_tick = ltick_q;
  assign logic_on_slow = slow_q;
  assign cp_ready = cp_q;

  // checking helpers: cycles in state, cycles supply good
  logic [17:0] age_q, ok_age_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      age_q <= '0;
      ok_age_q <= '0;
    end else begin
      age_q <= (state_d != state_q) ? 18'h00000 : age_q + {17'h00000, age_q != '1};
      ok_age_q <= !pin_q.vsup_ok ? 18'h00000 : ok_age_q + {17'h00000, ok_age_q != '1};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_por_hold;
    state_q == S_POR && state_d == S_PWRUP |-> ok_age_q >= POR_HOLD_CYC - 1'b1;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("reset hold too short"); // RULE_01
  property p_window;
    state_q == S_CHECK && state_d == S_FAIL |-> age_q >= CHECK_LEN - 1'b1;
  endproperty
  a_window: assert property (p_window) else $error("check window cut short"); // RULE_02
  property p_mrst;
    $fell(mrst_q) |-> $past(slow_tick);
  endproperty
  a_mrst: assert property (p_mrst) else $error("reset pulse not on slow tick"); // RULE_03
  property p_sysrst;
    state_q == S_SYSRST && state_d == S_PWRUP |-> age_q >= SYSRST_LEN - 1'b1;
  endproperty
  a_sysrst: assert property (p_sysrst) else $error("system reset too short"); // RULE_04
  property p_slow_step;
    $rose(supv_done) |-> $past(slow_tick);
  endproperty
  a_slow_step: assert property (p_slow_step) else $error("timer moved off slow tick"); // RULE_05
  property p_expire;
    supv_fire |=> mrst_q ##1 !mcu_rst_n;
  endproperty
  a_expire: assert property (p_expire) else $error("expiry gave no reset"); // RULE_06
  property p_tally;
    supv_fire && !tally_hit |=> tally_q == $past(tally_q) + 4'h1;
  endproperty
  a_tally: assert property (p_tally) else $error("tally not counted"); // RULE_08
  property p_global;
    state_q == S_SYSRST |=> sys_rst && !drivers_en;
  endproperty
  a_global: assert property (p_global) else $error("drivers on in global reset"); // RULE_09
  property p_div;
    logic_fast_tick |-> $past(fast_tick, 1) && !$past(logic_fast_tick, 1);
  endproperty
  a_div: assert property (p_div) else $error("logic tick off fast divider"); // RULE_10
  property p_sleep_clk;
    state_q == S_SLEEP |=> logic_on_slow;
  endproperty
  a_sleep_clk: assert property (p_sleep_clk) else $error("sleep not on slow clock"); // RULE_11
  property p_wake;
    $rose(wake_q) |-> $past(slow_tick) && $past(state_q) == S_SLEEP;
  endproperty
  a_wake: assert property (p_wake) else $error("wake sampled off slow tick"); // RULE_12
  property p_sleep_sup;
    state_q == S_SLEEP |=> !supply_en.sec_analog && !supply_en.periph && !supply_en.core_buf
      && supply_en.prim_analog && supply_en.basis_logic;
  endproperty
  a_sleep_sup: assert property (p_sleep_sup) else $error("sleep supply state wrong"); // RULE_13
  property p_cp;
    state_q == S_NORMAL && age_q >= CP_LEN |-> cp_ready;
  endproperty
  a_cp: assert property (p_cp) else $error("charge pump never ready"); // RULE_15
  property p_seq;
    $rose(supply_en.core_buf) |-> $past(state_q) == S_CHECK;
  endproperty
  a_seq: assert property (p_seq) else $error("supply on before check"); // RULE_16
  property p_release;
    state_q == S_NORMAL && !mrst_q |=> mcu_clk_en && mcu_rst_n;
  endproperty
  a_release: assert property (p_release) else $error("processor not released"); // RULE_17
  property p_fail;
    state_q == S_FAIL |=> !mcu_clk_en && !mcu_rst_n;
  endproperty
  a_fail: assert property (p_fail) else $error("processor released after failure"); // RULE_18
endmodule : system_supervisor_watchdog

// File: tb/mcu_side_model.sv
// processor-side supply flags, wake line and charge pump flag
`timescale 1ns/1ps
module mcu_side_model #(
  parameter int DLY = 40
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire supervisor_pkg::supply_en_t supply_en,
  input wire logic vsup,
  input wire logic wake,
  input wire logic sup_bad,
  input wire logic cp_flag,
  output supervisor_pkg::pin_in_t pins
);
  import supervisor_pkg::*;
  int cnt_q;
  // flags report valid only after the rails have been on for a while
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 0;
    end else if (supply_en.core_buf && supply_en.periph) begin
      cnt_q <= (cnt_q < DLY) ? cnt_q + 1 : cnt_q;
    end else begin
      cnt_q <= 0;
    end
  end
  // a bad core rail never reports valid, to exercise the missed window
  always_comb begin
    pins.vsup_ok = vsup;
    pins.core_ok = (cnt_q >= DLY) && !sup_bad;
    pins.periph_ok = cnt_q >= DLY;
    pins.cp_ok = cp_flag;
    pins.bus_wake = wake;
  end
endmodule : mcu_side_model

// File: tb/system_supervisor_watchdog_test.sv
// self-checking bench for the system supervisor
`timescale 1ns/1ps
module system_supervisor_watchdog_test;
  import supervisor_pkg::*;
  // short sequencer counts: 200, 300, 150, 250 cycles; supervision base of 4 slow ticks
  localparam logic [17:0] PW = 18'h000C8;
  localparam logic [17:0] CK = 18'h0012C;
  localparam logic [17:0] SR = 18'h00096;
  localparam logic [17:0] CP = 18'h000FA;
  localparam logic [17:0] ST = 18'h00004;
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'h0;
  logic rd_en = 1'h0;
  logic vsup = 1'h0;
  logic wake = 1'h0;
  logic sup_bad = 1'h0;
  logic cp_flag = 1'h0;
  logic [7:0] rdata;
  pin_in_t pins;
  supply_en_t supply_en;
  logic por_active, mcu_rst_n, mcu_clk_en, sys_rst, drivers_en, logic_tick, logic_on_slow, cp_ready;
  int n_fail = 0;
  int n_checks = 0;
  int n;

  always #5 sys_clk = ~sys_clk;

  system_supervisor_watchdog #(.PWRUP_LEN(PW), .CHECK_LEN(CK), .SYSRST_LEN(SR), .CP_LEN(CP), .SUPV_LEN(ST)) dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .pins(pins), .supply_en(supply_en), .por_active(por_active), .mcu_rst_n(mcu_rst_n),
    .mcu_clk_en(mcu_clk_en), .sys_rst(sys_rst), .drivers_en(drivers_en), .logic_tick(logic_tick),
    .logic_on_slow(logic_on_slow), .cp_ready(cp_ready));

  mcu_side_model #(.DLY(40)) model_u (
    .sys_clk(sys_clk), .resetn(resetn), .supply_en(supply_en), .vsup(vsup), .wake(wake),
    .sup_bad(sup_bad), .cp_flag(cp_flag), .pins(pins));

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : cmp8

  task automatic cmp1(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      $display("FAIL %s expected %b seen %b", nm, e, g);
      n_fail++;
    end
  endtask : cmp1

  task automatic cmp_rng(input string nm, input int lo, input int hi, input int g);
    n_checks++;
    if (g < lo || g > hi) begin
      $display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      n_fail++;
    end
  endtask : cmp_rng

  // cycles until the chosen output reaches val; running out ends the run
  task automatic wait_for(input int sel, input logic val, input int lim, output int cyc);
    logic s;
    cyc = 0;
    do begin
      @(posedge sys_clk);
      #1;
      cyc++;
      case (sel)
        0: s = por_active;
        1: s = supply_en.periph;
        2: s = logic_tick;
        3: s = cp_ready;
        5: s = sys_rst;
        default: s = mcu_rst_n;
      endcase
    end while (s !== val && cyc < lim);
    if (s !== val) begin
      $display("FAIL wait %0d expected %b seen %b", sel, val, s);
      n_fail++;
      conclude();
    end
  endtask : wait_for

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'h1;
    @(posedge sys_clk);
    wr_en <= 1'h0;
  endtask : wr

  task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge sys_clk);
    rd_en <= 1'h0;
    #1;
    cmp8(nm, e, rdata);
  endtask : rdc

  initial begin
    #1000000;
    $display("FAIL run time expected end seen none");
    n_fail++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'h1;
    @(posedge sys_clk);
    #1;
    cmp1("por_active", 1'h1, por_active);
    cmp1("mcu_rst_n", 1'h0, mcu_rst_n);
    cmp8("supply_en", 8'h00, {3'h0, supply_en});
    cmp1("sys_rst", 1'h0, sys_rst);
    @(posedge sys_clk);
    vsup <= 1'h1;
    wait_for(0, 1'h0, 9000, n);
    cmp_rng("por hold", 1000, 8000, n);
    cmp1("periph early", 1'h0, supply_en.periph);
    wait_for(1, 1'h1, 400, n);
    cmp_rng("power-up delay", int'(PW) - 2, int'(PW) + 4, n);
    rdc("state check", ADDR_STATE, 8'h04);
    wait_for(4, 1'h1, int'(CK), n);
    cmp1("mcu_clk_en", 1'h1, mcu_clk_en);
    cmp1("drivers_en", 1'h1, drivers_en);
    rdc("state normal", ADDR_STATE, 8'h08);
    // charge pump flag never comes, so readiness rests on the settle bound
    wait_for(3, 1'h1, int'(CP), n);
    wait_for(2, 1'h1, 30, n);
    wait_for(2, 1'h1, 30, n);
    cmp_rng("fast tick", 25, 25, n);
    wr(ADDR_CFG, 8'h05);
    rdc("cfg", ADDR_CFG, 8'h05);
    @(posedge sys_clk);
    #1;
    cmp8("rdata idle", 8'h00, rdata);
    rdc("unmapped", 4'h9, 8'h00);
    wr(ADDR_STATE, 8'hFF);
    rdc("state ro", ADDR_STATE, 8'h08);
    rdc("ctrl", ADDR_CTRL, 8'h00);
    rdc("stat", ADDR_STAT, 8'h80);
    // restarts span longer than the 8-tick timeout, so a lost restart shows in the tally
    repeat (20) begin
      wr(ADDR_CTRL, 8'h02);
      repeat (400) @(posedge sys_clk);
    end
    #1;
    cmp1("kicked", 1'h1, mcu_rst_n);
    rdc("stat kicked", ADDR_STAT, 8'h80);
    wr(ADDR_CTRL, 8'h01);
    repeat (2) @(posedge sys_clk);
    #1;
    cmp1("on slow", 1'h1, logic_on_slow);
    cmp8("sleep rails", 8'h12, {3'h0, supply_en});
    cmp1("sleep clk", 1'h0, mcu_clk_en);
    wait_for(2, 1'h1, 900, n);
    wait_for(2, 1'h1, 900, n);
    cmp_rng("slow tick", 800, 800, n);
    @(posedge sys_clk);
    wake <= 1'h1;
    wait_for(4, 1'h1, 2500, n);
    @(posedge sys_clk);
    wake <= 1'h0;
    #1;
    cmp1("on fast", 1'h0, logic_on_slow);
    cmp8("normal rails", 8'h1F, {3'h0, supply_en});
    // timer left alone: expiries count up to the limit of 8
    wr(ADDR_CFG, 8'h04);
    wr(ADDR_CTRL, 8'h02);
    wait_for(4, 1'h0, 4000, n);
    cmp_rng("timeout", int'(ST - 1) * SLOW_DIV, int'(ST) * SLOW_DIV + 2, n);
    rdc("stat fired", ADDR_STAT, 8'hC1);
    wait_for(4, 1'h1, 900, n);
    cmp_rng("reset pulse", SLOW_DIV - 10, SLOW_DIV + 2, n);
    repeat (3) begin
      wait_for(4, 1'h0, 3300, n);
      wait_for(4, 1'h1, 900, n);
    end
    rdc("stat four", ADDR_STAT, 8'h84);
    cmp1("no escalation", 1'h0, sys_rst);
    wait_for(5, 1'h1, 13000, n);
    cmp1("drivers off", 1'h0, drivers_en);
    cmp8("global rails", 8'h12, {3'h0, supply_en});
    wait_for(5, 1'h0, 400, n);
    cmp_rng("system reset", int'(SR), int'(SR) + 2, n);
    rdc("tally cleared", ADDR_STAT, 8'h40);
    wait_for(4, 1'h1, 2000, n);
    cmp1("drivers back", 1'h1, drivers_en);
    // brown-out, then a core rail that never reports valid
    @(posedge sys_clk);
    sup_bad <= 1'h1;
    vsup <= 1'h0;
    repeat (5) @(posedge sys_clk);
    #1;
    cmp1("por again", 1'h1, por_active);
    @(posedge sys_clk);
    vsup <= 1'h1;
    wait_for(0, 1'h0, 9000, n);
    wait_for(1, 1'h1, 400, n);
    repeat (int'(CK) - 30) @(posedge sys_clk);
    rdc("in window", ADDR_STATE, 8'h04);
    repeat (40) @(posedge sys_clk);
    rdc("state fail", ADDR_STATE, 8'h40);
    cmp1("fail rst", 1'h0, mcu_rst_n);
    cmp1("fail clk", 1'h0, mcu_clk_en);
    conclude();
  end
endmodule : system_supervisor_watchdog_test
